// ### include/gpro_pkg.sv
package gpro_pkg;

  // Sideband request port geometry
  localparam int          SBP_W         = 8;
  localparam logic [7:0]  IDLE_TICK     = 8'hff;
  localparam int          ADDR_HI       = 35;
  localparam int          ADDR_LO       = 3;
  localparam int          ADDR_W        = ADDR_HI - ADDR_LO + 1;
  localparam int          LEN_W         = 3;
  localparam int          CMD_W         = 4;
  localparam int          DATA_W        = 64;

  // Opcode positions in the leading tick
  localparam int          OP1_BIT       = 7;
  localparam logic [1:0]  OP2_CODE      = 2'h2;
  localparam logic [2:0]  OP3_CODE      = 3'h6;

  // Field positions of the mid-address operation (leading tick)
  localparam int          MID_CMD_HI    = 5;
  localparam int          MID_CMD_LO    = 2;
  localparam int          MID_A15_BIT   = 0;

  // Field positions of the upper-address operation (leading tick)
  localparam int          UP_A35_HI     = 3;

  // Command classification: this bit set marks a write
  localparam int          CMD_WRITE_BIT = 2;

  // Reset values of the retained registers
  localparam logic [12:0] MID_RESET     = 13'h0000;
  localparam logic [11:0] UP_RESET      = 12'h000;

  // Queue depths and write sequence counter width
  localparam int          RD_DEPTH_DEF  = 8;
  localparam int          WR_DEPTH_DEF  = 8;
  localparam int          SEQ_W         = 16;

endpackage

// ### rtl/gpro_fifo.sv
`timescale 1ns/1ps
module gpro_fifo
  import gpro_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("gpro_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0]  wr_q, wr_d, rd_q, rd_d;
  logic         push, pop;

  // Pointers carry one extra bit so full and empty are told apart
  always_comb begin
    in_ready  = (wr_q - rd_q) != PW'(0) + (PW + 1)'(DEPTH);
    out_valid = wr_q != rd_q;
    out_data  = mem_q[rd_q[PW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; only slots behind the write pointer are read
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

endmodule

// ### rtl/gpro_sba_decode.sv
`timescale 1ns/1ps
module gpro_sba_decode
  import gpro_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Mode
  input  wire logic              port_enable,
  input  wire logic              rate_2x,
  // Synchronised ticks (second used only at double rate)
  input  wire logic [SBP_W-1:0]  tick_a,
  input  wire logic [SBP_W-1:0]  tick_b,
  // Rebuilt access
  output logic                   acc_valid,
  output logic [ADDR_W-1:0]      acc_addr,
  output logic [LEN_W-1:0]       acc_len,
  output logic [CMD_W-1:0]       acc_cmd,
  output logic                   sticky_loaded
);
  logic             half_q, half_d;
  logic [7:0]       first_q, first_d;
  logic [12:0]      mid_q, mid_d;
  logic [11:0]      up_q, up_d;
  logic             mid_seen_q, mid_seen_d, up_seen_q, up_seen_d;
  logic             acc_valid_d;
  logic [ADDR_W-1:0] acc_addr_d;
  logic [LEN_W-1:0] acc_len_d;
  logic [CMD_W-1:0] acc_cmd_d;
  logic             op_vld;
  logic [7:0]       op_hi, op_lo;

  // Tick pairing, opcode decode and merge with the retained fields
  always_comb begin
    half_d      = half_q;
    first_d     = first_q;
    op_vld      = 1'b0;
    op_hi       = tick_a;
    op_lo       = tick_b;
    if (rate_2x) begin
      op_vld = tick_a != IDLE_TICK;
      half_d = 1'b0;
    end else if (!half_q) begin
      if (tick_a != IDLE_TICK) begin
        first_d = tick_a;
        half_d  = 1'b1;
      end
    end else begin
      op_vld = 1'b1;
      op_hi  = first_q;
      op_lo  = tick_a;
      half_d = 1'b0;
    end
    if (!port_enable) begin
      op_vld = 1'b0;
      half_d = 1'b0;
    end
    mid_d       = mid_q;
    up_d        = up_q;
    mid_seen_d  = mid_seen_q && port_enable;
    up_seen_d   = up_seen_q && port_enable;
    acc_valid_d = 1'b0;
    acc_addr_d  = {up_q, mid_q[7:0], mid_q[8], op_hi[6:0], op_lo[7:3]};
    acc_len_d   = op_lo[2:0];
    acc_cmd_d   = mid_q[12:9];
    if (op_vld) begin
      if (!op_hi[OP1_BIT]) begin
        acc_valid_d = 1'b1;
      end else if (op_hi[7:6] == OP2_CODE) begin
        mid_d      = {op_hi[MID_CMD_HI:MID_CMD_LO], op_hi[MID_A15_BIT], op_lo};
        mid_seen_d = 1'b1;
      end else if (op_hi[7:5] == OP3_CODE) begin
        up_d      = {op_hi[UP_A35_HI:0], op_lo};
        up_seen_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_q     <= 1'b0;
      first_q    <= IDLE_TICK;
      mid_q      <= MID_RESET;
      up_q       <= UP_RESET;
      mid_seen_q <= 1'b0;
      up_seen_q  <= 1'b0;
      acc_valid  <= 1'b0;
      acc_addr   <= '0;
      acc_len    <= '0;
      acc_cmd    <= '0;
    end else if (clk_en) begin
      half_q     <= half_d;
      first_q    <= first_d;
      mid_q      <= mid_d;
      up_q       <= up_d;
      mid_seen_q <= mid_seen_d;
      up_seen_q  <= up_seen_d;
      acc_valid  <= acc_valid_d;
      acc_addr   <= acc_addr_d;
      acc_len    <= acc_len_d;
      acc_cmd    <= acc_cmd_d;
    end
  end

  assign sticky_loaded = mid_seen_q && up_seen_q;

endmodule

// ### rtl/gpro_top.sv
// Summary of operation
// - Only a low-address operation starts an access; others just update retained fields.
// - The three operation types may arrive in any order; each low-address one queues unless its queue or, for a read, the return slots are full.
// - Before mid and upper fields are loaded, their bits in an access are undefined; here they read as the zero reset values.
// - Low-address bits and length merge with retained mid, upper and command fields.
// - No framing strobe exists; the byte encoding alone marks a request.
// - Retained mid, upper and command fields never change during idle fill.
// - Operations start on a rising clock; idle is one tick single rate, two double.
// - No ordering against processor, PCI or expansion traffic; locks are not honoured.
// - Reads use main memory and writes go there without snooping caches.
// - No ordering between port and PCI streams; each keeps its own order.
// - Read data returns to the master in request order.
// - Memory may serve queued reads in any order; return order is still kept.
// - Writes complete in request order so later bytes overwrite earlier ones.
// - A read waits for all earlier writes, so it sees the latest data.
// - A write may go ahead of earlier reads, so reads may see newer data.
// - PCI transactions from port agents follow PCI ordering, not these rules.
// - These ordering rules cover normal priority only; high priority is separate.
// - Low-address: opcode 0, address 14 to 3, 3-bit length, bits 2 to 0 zero.
// - Mid-address: opcode 10, 4-bit command, address 23 to 15.
// - Upper-address: opcode 110, address 35 to 24, bits 35 to 32 reserved for growth.
// - Each 16-bit operation takes two clocks single rate, one clock double rate.
`timescale 1ns/1ps
module gpro_top
  import gpro_pkg::*;
#(
  parameter  int RD_DEPTH = RD_DEPTH_DEF,
  parameter  int WR_DEPTH = WR_DEPTH_DEF,
  localparam int TAG_W    = $clog2(RD_DEPTH)
) (
  // Clock, reset and freeze
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  // Port mode
  input  wire logic              port_enable,
  input  wire logic              rate_2x,
  // Sideband request port pins (tick b carries the second tick at double rate)
  input  wire logic [SBP_W-1:0]  sideband_request_port_a,
  input  wire logic [SBP_W-1:0]  sideband_request_port_b,
  // Memory write issue
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic [ADDR_W-1:0]      mem_wr_addr,
  output logic [LEN_W-1:0]       mem_wr_len,
  output logic [CMD_W-1:0]       mem_wr_cmd,
  // Memory read issue
  output logic                   mem_rd_valid,
  input  wire logic              mem_rd_ready,
  output logic [ADDR_W-1:0]      mem_rd_addr,
  output logic [LEN_W-1:0]       mem_rd_len,
  output logic [CMD_W-1:0]       mem_rd_cmd,
  output logic [TAG_W-1:0]       mem_rd_tag,
  // Memory read data, any order
  input  wire logic              mem_rdat_valid,
  input  wire logic [TAG_W-1:0]  mem_rdat_tag,
  input  wire logic [DATA_W-1:0] mem_rdat,
  // Read return to the master, in request order
  output logic                   ret_valid,
  input  wire logic              ret_ready,
  output logic [DATA_W-1:0]      ret_data,
  // Status
  output logic                   req_dropped,
  output logic                   sticky_loaded
);
  localparam int WR_ENT_W = CMD_W + LEN_W + ADDR_W;
  localparam int RD_ENT_W = SEQ_W + TAG_W + WR_ENT_W;

  generate
    if (RD_DEPTH < 2 || (RD_DEPTH & (RD_DEPTH - 1)) != 0) begin : g_bad_rd
      $error("gpro_top: RD_DEPTH must be a power of two of at least 2");
    end
    if (WR_DEPTH < 2 || (WR_DEPTH & (WR_DEPTH - 1)) != 0) begin : g_bad_wr
      $error("gpro_top: WR_DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pins come from the master's launch clock, so two flops before any decode.
  // Idle fill is the reset value so nothing is seen as a request while filling.
  logic [SBP_W-1:0] pin_a_meta_q, pin_a_q, pin_b_meta_q, pin_b_q;
  logic [SBP_W-1:0] pin_a_meta_d, pin_a_d, pin_b_meta_d, pin_b_d;
  always_comb begin
    pin_a_meta_d = sideband_request_port_a;
    pin_a_d      = pin_a_meta_q;
    pin_b_meta_d = sideband_request_port_b;
    pin_b_d      = pin_b_meta_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_a_meta_q <= IDLE_TICK;
      pin_a_q      <= IDLE_TICK;
      pin_b_meta_q <= IDLE_TICK;
      pin_b_q      <= IDLE_TICK;
    end else if (clk_en) begin
      pin_a_meta_q <= pin_a_meta_d;
      pin_a_q      <= pin_a_d;
      pin_b_meta_q <= pin_b_meta_d;
      pin_b_q      <= pin_b_d;
    end
  end

  // Operation decode and access rebuild
  logic              acc_valid;
  logic [ADDR_W-1:0] acc_addr;
  logic [LEN_W-1:0]  acc_len;
  logic [CMD_W-1:0]  acc_cmd;

  gpro_sba_decode u_decode (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n_q),
    .clk_en        (clk_en),
    .port_enable   (port_enable),
    .rate_2x       (rate_2x),
    .tick_a        (pin_a_q),
    .tick_b        (pin_b_q),
    .acc_valid     (acc_valid),
    .acc_addr      (acc_addr),
    .acc_len       (acc_len),
    .acc_cmd       (acc_cmd),
    .sticky_loaded (sticky_loaded)
  );

  // Steering of each new access to its own queue
  logic                acc_is_wr;
  logic                wq_in_valid, wq_in_ready, wq_out_valid, wq_out_ready;
  logic [WR_ENT_W-1:0] wq_out_data;
  logic                rq_in_valid, rq_in_ready, rq_out_valid, rq_out_ready;
  logic [RD_ENT_W-1:0] rq_out_data;
  logic [SEQ_W-1:0]    wr_enq_q, wr_enq_d, wr_iss_q, wr_iss_d;
  logic [TAG_W-1:0]    alloc_q, alloc_d, ret_q, ret_d;
  logic [TAG_W:0]      rob_cnt_q, rob_cnt_d;
  logic                rob_room, rd_accept, rd_issue, rd_barrier_ok, ret_fire;
  logic                dropped_d;
  logic [SEQ_W-1:0]    rd_barrier, barrier_gap;

  // Each access is queued the cycle it is rebuilt unless its queue or, for a read, the return slots are full, whatever order the types came in
  always_comb begin
    acc_is_wr   = acc_cmd[CMD_WRITE_BIT];
    rob_room    = rob_cnt_q != (TAG_W + 1)'(RD_DEPTH);
    wq_in_valid = acc_valid && acc_is_wr;
    rq_in_valid = acc_valid && !acc_is_wr && rob_room;
    rd_accept   = rq_in_valid && rq_in_ready;
    // Flow control is outside this block, so an overrun is only reported
    dropped_d   = acc_valid && (acc_is_wr ? !wq_in_ready : !(rob_room && rq_in_ready));
  end

  gpro_fifo #(
    .W     (WR_ENT_W),
    .DEPTH (WR_DEPTH)
  ) u_wr_queue (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_q),
    .clk_en    (clk_en),
    .in_valid  (wq_in_valid),
    .in_ready  (wq_in_ready),
    .in_data   ({acc_cmd, acc_len, acc_addr}),
    .out_valid (wq_out_valid),
    .out_ready (wq_out_ready),
    .out_data  (wq_out_data)
  );

  // Reads carry the count of writes queued before them and their return slot
  gpro_fifo #(
    .W     (RD_ENT_W),
    .DEPTH (RD_DEPTH)
  ) u_rd_queue (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_q),
    .clk_en    (clk_en),
    .in_valid  (rq_in_valid),
    .in_ready  (rq_in_ready),
    .in_data   ({wr_enq_q, alloc_q, acc_cmd, acc_len, acc_addr}),
    .out_valid (rq_out_valid),
    .out_ready (rq_out_ready),
    .out_data  (rq_out_data)
  );

  // Write issue: strictly in queue order, never held behind reads
  always_comb begin
    mem_wr_valid = wq_out_valid;
    wq_out_ready = mem_wr_ready;
    {mem_wr_cmd, mem_wr_len, mem_wr_addr} = wq_out_data;
  end

  // Read issue: held until every write queued ahead of it has gone to memory.
  // Modular compare tolerates counter wrap while fewer than 2^15 writes overtake.
  always_comb begin
    rd_barrier    = rq_out_data[RD_ENT_W-1 -: SEQ_W];
    barrier_gap   = wr_iss_q - rd_barrier;
    rd_barrier_ok = !barrier_gap[SEQ_W-1];
    mem_rd_valid  = rq_out_valid && rd_barrier_ok;
    rd_issue      = mem_rd_valid && mem_rd_ready;
    rq_out_ready  = rd_barrier_ok && mem_rd_ready;
    mem_rd_tag    = rq_out_data[WR_ENT_W +: TAG_W];
    {mem_rd_cmd, mem_rd_len, mem_rd_addr} = rq_out_data[WR_ENT_W-1:0];
  end

  // Write sequence counters shared by the read barrier
  always_comb begin
    wr_enq_d = wr_enq_q + SEQ_W'(wq_in_valid && wq_in_ready);
    wr_iss_d = wr_iss_q + SEQ_W'(mem_wr_valid && mem_wr_ready);
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_enq_q    <= '0;
      wr_iss_q    <= '0;
      req_dropped <= 1'b0;
    end else if (clk_en) begin
      wr_enq_q    <= wr_enq_d;
      wr_iss_q    <= wr_iss_d;
      req_dropped <= dropped_d;
    end
  end

  // Return buffer: memory fills slots by tag in any order, master drains in order
  logic [DATA_W-1:0] rob_data_q [RD_DEPTH];
  logic [RD_DEPTH-1:0] rob_full_q, rob_full_d;

  always_comb begin
    ret_valid = rob_full_q[ret_q];
    ret_data  = rob_data_q[ret_q];
    ret_fire  = ret_valid && ret_ready;
    alloc_d   = rd_accept ? alloc_q + 1'b1 : alloc_q;
    ret_d     = ret_fire ? ret_q + 1'b1 : ret_q;
    rob_cnt_d = rob_cnt_q + (TAG_W + 1)'(rd_accept) - (TAG_W + 1)'(ret_fire);
  end

  // Per-slot fill flag; a fill into a slot wins over its drain
  genvar gi;
  generate
    for (gi = 0; gi < RD_DEPTH; gi++) begin : g_slot
      always_comb begin
        rob_full_d[gi] = rob_full_q[gi];
        if (ret_fire && ret_q == TAG_W'(gi)) begin
          rob_full_d[gi] = 1'b0;
        end
        if (mem_rdat_valid && mem_rdat_tag == TAG_W'(gi)) begin
          rob_full_d[gi] = 1'b1;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (clk_en && mem_rdat_valid && mem_rdat_tag == TAG_W'(gi)) begin
          rob_data_q[gi] <= mem_rdat;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rob_full_q <= '0;
      alloc_q    <= '0;
      ret_q      <= '0;
      rob_cnt_q  <= '0;
    end else if (clk_en) begin
      rob_full_q <= rob_full_d;
      alloc_q    <= alloc_d;
      ret_q      <= ret_d;
      rob_cnt_q  <= rob_cnt_d;
    end
  end

  // Nothing here looks at processor, PCI or cache state; reads and writes go
  // straight to memory unsnooped and unlocked, so no such ports exist.

endmodule

// ### testbench/gpro_top_properties.sv
`timescale 1ns/1ps
module gpro_top_props
  import gpro_pkg::*;
#(
  parameter int RD_DEPTH = RD_DEPTH_DEF
) (
  // Clock, reset, mode and pins
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              clk_en,
  input wire logic              port_enable,
  input wire logic              rate_2x,
  input wire logic [SBP_W-1:0]  sideband_request_port_a,
  // Memory side
  input wire logic              mem_wr_valid,
  input wire logic              mem_wr_ready,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic              mem_rd_valid,
  input wire logic              mem_rd_ready,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic              mem_rdat_valid,
  // Return side and status
  input wire logic              ret_valid,
  input wire logic              ret_ready,
  input wire logic [DATA_W-1:0] ret_data,
  input wire logic              req_dropped,
  input wire logic              sticky_loaded
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Reads issued but not returned, and data held but not returned
  logic [7:0] out_q, out_d, got_q, got_d;
  logic       rd_go, ret_go;
  always_comb begin
    rd_go = mem_rd_valid && mem_rd_ready && clk_en;
    ret_go = ret_valid && ret_ready && clk_en;
    out_d = out_q + 8'(rd_go) - 8'(ret_go);
    got_d = got_q + 8'(mem_rdat_valid && clk_en) - 8'(ret_go);
  end
  // Counters reset with the pin so they never carry stale counts across a reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_q <= 8'h00;
      got_q <= 8'h00;
    end else begin
      out_q <= out_d;
      got_q <= got_d;
    end
  end

  a_wr_req_holds: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr)) else $error("write request not held");
  a_rd_req_holds: assert property (mem_rd_valid && !mem_rd_ready |=>
    mem_rd_valid && $stable(mem_rd_addr)) else $error("read request not held");
  a_ret_holds: assert property (ret_valid && !ret_ready |=>
    ret_valid && $stable(ret_data)) else $error("return data not held");
  a_ret_has_data: assert property (ret_valid |-> got_q != 8'h00)
    else $error("return offered with no memory data");
  a_rd_slot_free: assert property (mem_rd_valid |-> out_q < RD_DEPTH)
    else $error("read issued with every return slot busy");
  a_idle_no_write: assert property (
    (clk_en && rate_2x && sideband_request_port_a == IDLE_TICK)[*6] |-> !$rose(mem_wr_valid))
    else $error("write appeared during idle fill");
  a_quiet_reset: assert property ($rose(rstn) |->
    (!mem_wr_valid && !mem_rd_valid && !ret_valid)[*2]) else $error("access out of reset");
  a_off_clears_loaded: assert property (
    (clk_en && !port_enable)[*3] |-> !sticky_loaded) else $error("loaded flag kept");

  c_write: cover property (mem_wr_valid && mem_wr_ready);
  c_read: cover property (mem_rd_valid && mem_rd_ready);
  c_return: cover property (ret_valid && ret_ready);
  c_drop: cover property (req_dropped);
endmodule

bind gpro_top gpro_top_props #(.RD_DEPTH(RD_DEPTH)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .port_enable(port_enable),
  .rate_2x(rate_2x), .sideband_request_port_a(sideband_request_port_a),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
  .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr),
  .mem_rdat_valid(mem_rdat_valid), .ret_valid(ret_valid), .ret_ready(ret_ready),
  .ret_data(ret_data), .req_dropped(req_dropped), .sticky_loaded(sticky_loaded));

// ### testbench/gpro_master_model.sv
`timescale 1ns/1ps
module gpro_master_model
  import gpro_pkg::*;
(
  // Clock and mode
  input wire logic             clk_sys,
  input wire logic             rate_2x,
  // Sideband pins towards the target
  output logic [SBP_W-1:0]     port_a,
  output logic [SBP_W-1:0]     port_b
);
  // No strobe exists, so idle fill is the only way to say nothing
  initial begin
    port_a = IDLE_TICK;
    port_b = IDLE_TICK;
  end
  // One normal-priority operation from a rising edge; never needs old data or a sync event
  task automatic send(input logic [15:0] op);
    @(posedge clk_sys);
    port_a <= op[15:8];
    if (rate_2x) begin
      port_b <= op[7:0];
    end else begin
      @(posedge clk_sys);
      port_a <= op[7:0];
    end
  endtask
  // Idle fill; both ticks of a double-rate clock carry all ones
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      port_a <= IDLE_TICK;
      port_b <= IDLE_TICK;
    end
  endtask
endmodule

// ### testbench/graphics_port_request_ordering_test.sv
`timescale 1ns/1ps
module graphics_port_request_ordering_test;
  import gpro_pkg::*;
  localparam int               TW = $clog2(RD_DEPTH_DEF);
  localparam logic [CMD_W-1:0] CW = 4'h4;
  localparam logic [CMD_W-1:0] CR = 4'h0;
  // Stimulus, pins and outputs
  logic              clk_sys, rstn, clk_en, port_enable, rate_2x, mem_wr_ready, mem_rd_ready;
  logic              mem_wr_valid, mem_rd_valid, mem_rdat_valid, ret_valid, ret_ready;
  logic              req_dropped, sticky_loaded;
  logic [SBP_W-1:0]  sba_a, sba_b;
  logic [ADDR_W-1:0] mem_wr_addr, mem_rd_addr;
  logic [LEN_W-1:0]  mem_wr_len, mem_rd_len;
  logic [CMD_W-1:0]  mem_wr_cmd, mem_rd_cmd;
  logic [TW-1:0]     mem_rd_tag, mem_rdat_tag;
  logic [DATA_W-1:0] mem_rdat, ret_data;
  // Completed handshakes and expected read addresses in request order
  logic [39:0]       wr_q[$], rd_q[$];
  logic [TW-1:0]     tg_q[$];
  logic [DATA_W-1:0] ret_q[$];
  logic [ADDR_W-1:0] ea_q[$];
  int                miscompares, tests_run, cycles, drops;

  gpro_top dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .port_enable(port_enable),
    .rate_2x(rate_2x), .sideband_request_port_a(sba_a), .sideband_request_port_b(sba_b),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_len(mem_wr_len), .mem_wr_cmd(mem_wr_cmd), .mem_rd_valid(mem_rd_valid),
    .mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr), .mem_rd_len(mem_rd_len),
    .mem_rd_cmd(mem_rd_cmd), .mem_rd_tag(mem_rd_tag), .mem_rdat_valid(mem_rdat_valid),
    .mem_rdat_tag(mem_rdat_tag), .mem_rdat(mem_rdat), .ret_valid(ret_valid),
    .ret_ready(ret_ready), .ret_data(ret_data), .req_dropped(req_dropped),
    .sticky_loaded(sticky_loaded));
  gpro_master_model master (.clk_sys(clk_sys), .rate_2x(rate_2x), .port_a(sba_a),
    .port_b(sba_b));

  // 125 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Log handshakes where both sides agree; the cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (mem_wr_valid === 1'h1 && mem_wr_ready)
      wr_q.push_back({mem_wr_cmd, mem_wr_len, mem_wr_addr});
    if (mem_rd_valid === 1'h1 && mem_rd_ready) begin
      rd_q.push_back({mem_rd_cmd, mem_rd_len, mem_rd_addr});
      tg_q.push_back(mem_rd_tag);
    end
    if (ret_valid === 1'h1 && ret_ready)
      ret_q.push_back(ret_data);
    if (req_dropped === 1'h1)
      drops++;
    if (cycles == 3000) begin
      miscompares++;
      $display("Error at %0t: cycles %h limit %h", $time, cycles, 3000);
      report_and_stop();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Operation encodings; index 0 of an address is bit 3
  function automatic logic [15:0] op1(input logic [ADDR_W-1:0] x, input logic [LEN_W-1:0] n);
    return {1'h0, x[11:0], n};
  endfunction
  function automatic logic [15:0] op2(input logic [ADDR_W-1:0] x, input logic [CMD_W-1:0] c);
    return {2'h2, c, 1'h0, x[12], x[20:13]};
  endfunction
  function automatic logic [15:0] op3(input logic [ADDR_W-1:0] x);
    return {3'h6, 1'h0, x[32:21]};
  endfunction
  task automatic full(input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n,
                      input logic [CMD_W-1:0] c);
    master.send(op3(a));
    master.send(op2(a, c));
    master.send(op1(a, n));
  endtask

  // Single rate: retained fields merge with each low-address request
  task automatic t_sticky();
    logic [ADDR_W-1:0] x;
    x = 33'h1_2345_6789;
    mem_wr_ready <= 1'h1;
    chk(64'(sticky_loaded), 64'h0);
    master.send(op2(x, CW));
    master.send(op3(x));
    master.idle(8);
    chk(64'(wr_q.size() + rd_q.size()), 64'h0);
    chk(64'(sticky_loaded), 64'h1);
    master.send(op1(x, 3'h2));
    master.send(op1({x[32:12], 12'hfff}, 3'h7));
    master.idle(20);
    master.send(op1({x[32:12], 12'h008}, 3'h0));
    master.idle(8);
    chk(64'(wr_q.size()), 64'h3);
    chk(64'(wr_q[0]), 64'({CW, 3'h2, x}));
    chk(64'(wr_q[1]), 64'({CW, 3'h7, x[32:12], 12'hfff}));
    chk(64'(wr_q[2]), 64'({CW, 3'h0, x[32:12], 12'h008}));
  endtask
  // Double rate: reads wait for older writes, newer writes pass stalled reads
  task automatic t_order();
    logic [ADDR_W-1:0] y;
    y = 33'h0_abcd_e123;
    wr_q.delete();
    rate_2x <= 1'h1;
    mem_wr_ready <= 1'h0;
    mem_rd_ready <= 1'h1;
    master.idle(2);
    full(y, 3'h1, CW);
    full(y ^ 33'h10, 3'h1, CR);
    master.send(op1(y ^ 33'h20, 3'h3));
    ea_q = '{y ^ 33'h10, y ^ 33'h20};
    master.idle(8);
    chk(64'(mem_wr_valid), 64'h1);
    chk(64'(rd_q.size()), 64'h0);
    mem_rd_ready <= 1'h0;
    master.send(op2(y, CW));
    master.send(op1(y ^ 33'h30, 3'h1));
    master.idle(2);
    mem_wr_ready <= 1'h1;
    master.idle(8);
    chk(64'(wr_q[1]), 64'({CW, 3'h1, y ^ 33'h30}));
    chk(64'(wr_q.size()), 64'h2);
    mem_rd_ready <= 1'h1;
    master.idle(8);
    chk(64'(rd_q[1]), 64'({CR, 3'h3, y ^ 33'h20}));
  endtask
  // Fill every return slot, overflow by one, answer in reverse with the master stalled
  task automatic t_fill();
    logic [ADDR_W-1:0] z;
    z = 33'h0_5a5a_5000;
    full(z, 3'h0, CR);
    ea_q.push_back(z);
    for (int i = 1; i < 7; i++) begin
      master.send(op1(z + 33'(i * 8), 3'h0));
      if (i < 6)
        ea_q.push_back(z + 33'(i * 8));
    end
    master.idle(10);
    chk(64'(drops), 64'h1);
    chk(64'(rd_q.size()), 64'h8);
    for (int k = 7; k >= 0; k--) begin
      @(posedge clk_sys);
      mem_rdat_valid <= 1'h1;
      mem_rdat_tag <= tg_q[k];
      mem_rdat <= 64'(rd_q[k][ADDR_W-1:0]);
    end
    @(posedge clk_sys);
    mem_rdat_valid <= 1'h0;
    repeat (4) @(posedge clk_sys);
    ret_ready <= 1'h1;
    repeat (16) @(posedge clk_sys);
    chk(64'(ret_q.size()), 64'h8);
    for (int k = 0; k < 8; k++)
      chk(ret_q[k], 64'(ea_q[k]));
  endtask
  // Hold reset four clocks, then expect quiet outputs
  task automatic t_reset();
    rstn <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk(64'({mem_wr_valid, mem_rd_valid, ret_valid, sticky_loaded}), 64'h0);
  endtask
  // Freeze and disable together, then unfreeze, then reset again
  task automatic t_pause();
    {clk_en, port_enable, rate_2x, ret_ready} <= 4'h0;
    repeat (4) @(posedge clk_sys);
    chk(64'(sticky_loaded), 64'h1);
    clk_en <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk(64'(sticky_loaded), 64'h0);
    t_reset();
  endtask

  // Main sequence: reset, enable, run each case
  initial begin
    {port_enable, rate_2x, mem_wr_ready, mem_rd_ready, ret_ready} = 5'h00;
    clk_en = 1'h1;
    mem_rdat_valid = 1'h0;
    mem_rdat_tag = 3'h0;
    mem_rdat = 64'h0;
    t_reset();
    port_enable <= 1'h1;
    repeat (3) @(posedge clk_sys);
    t_sticky();
    t_order();
    t_fill();
    t_pause();
    report_and_stop();
  end
endmodule
